// [verilog/ipc_injector_peak_hold_ctrl.sv]
`timescale 1ns/10ps
// Functional notes
// - Four channels, each timed and run independently
// - Event start regulates at peak for peak time
// - After peak time, hold level until event end
// - Peak time taken up every 200 us
// - No level reached in event: report open
// - Fast rise at event start sets short
// - Short flag keeps channel disabled until cleared
// - Short checked continuously later in event
// - Short clear ignored while event commanded
// - Same logic for high and low impedance
// - Nonzero peak time always targets peak level
// - Peak time expiry, not reaching hold level, starts hold regulation
module ipc_injector_peak_hold_ctrl
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Host commands, same clock domain
    input wire logic [ipc_pkg::NCH-1:0] inject_cmd_in,
    input wire logic [ipc_pkg::PEAK_W-1:0] peak_time_in,
    input wire logic [ipc_pkg::NCH-1:0] short_clear_in,
    input wire logic [ipc_pkg::NCH-1:0] open_clear_in,
    // Analogue stage sense lines
    input wire ipc_pkg::ipc_sense_t sense_in,
    // Driver controls
    output logic [ipc_pkg::NCH-1:0] drive_on_out,
    output logic [ipc_pkg::NCH-1:0] target_peak_out,
    output logic [ipc_pkg::NCH-1:0] chop_out,
    // Status
    output logic [ipc_pkg::NCH-1:0] short_flag_out,
    output logic [ipc_pkg::NCH-1:0] open_flag_out,
    output logic [ipc_pkg::PEAK_W-1:0] peak_time_out,
    output logic peak_update_out
);

    ipc_pkg::ipc_state_t s;
    ipc_pkg::ipc_state_t next_s;
    ipc_pkg::ipc_sense_t sense;

    logic [$bits(ipc_pkg::ipc_sense_t)-1:0] sense_sync;

    ipc_sync
    #(
        .W($bits(ipc_pkg::ipc_sense_t))
    )
    u_sync
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(sense_in),
        .sync_out(sense_sync)
    );

    assign sense = ipc_pkg::ipc_sense_t'(sense_sync);

    always_comb
    begin
        logic tick;
        logic cmd;
        logic start;
        logic hit;
        logic short_set;
        logic open_set;
        ipc_pkg::ipc_chan_t c;
        tick = 1'b0;
        cmd = 1'b0;
        start = 1'b0;
        hit = 1'b0;
        short_set = 1'b0;
        open_set = 1'b0;
        c = '0;
        next_s = s;
        next_s.upd_pulse = 1'b0;

        // Microsecond tick shared by all channels
        tick = (s.us_div == ipc_pkg::US_LAST);
        next_s.us_div = tick ? '0 : s.us_div + 1'b1;

        // Fixed-interval take-up of the requested peak time
        if (tick)
        begin
            if (s.upd_cnt == ipc_pkg::UPD_LAST)
            begin
                next_s.upd_cnt = '0;
                next_s.peak_time = peak_time_in;
                next_s.upd_pulse = 1'b1;
            end
            else
            begin
                next_s.upd_cnt = s.upd_cnt + 1'b1;
            end
        end

        // Each channel evolves from its own command alone
        for (int i = 0; i < ipc_pkg::NCH; i++)
        begin
            c = s.ch[i];
            cmd = inject_cmd_in[i];
            start = cmd && !s.ch[i].cmd_prev;
            c.cmd_prev = cmd;
            hit = sense.at_peak[i] || sense.at_hold[i];
            short_set = 1'b0;
            open_set = 1'b0;
            case (s.ch[i].phase)
                ipc_pkg::IPC_IDLE:
                begin
                    // A shorted channel refuses new events
                    if (start && !s.ch[i].short_flag)
                    begin
                        // No impedance setting: zero peak time goes to hold directly
                        c.phase = (s.peak_time != ipc_pkg::PEAK_RESET) ?
                            ipc_pkg::IPC_PEAK : ipc_pkg::IPC_HOLD;
                        c.peak_cnt = s.peak_time;
                        c.win_cnt = ipc_pkg::WIN_LOAD;
                        c.reached = 1'b0;
                    end
                end
                ipc_pkg::IPC_PEAK, ipc_pkg::IPC_HOLD:
                begin
                    if (tick && s.ch[i].win_cnt != '0)
                    begin
                        c.win_cnt = s.ch[i].win_cnt - 1'b1;
                    end
                    if (s.ch[i].phase == ipc_pkg::IPC_PEAK && tick)
                    begin
                        if (s.ch[i].peak_cnt <= 16'h0001)
                        begin
                            c.phase = ipc_pkg::IPC_HOLD;
                        end
                        else
                        begin
                            c.peak_cnt = s.ch[i].peak_cnt - 1'b1;
                        end
                    end
                    if (hit)
                    begin
                        c.reached = 1'b1;
                    end
                    if (s.ch[i].win_cnt != '0)
                    begin
                        short_set = sense.rise_fast[i];
                    end
                    else
                    begin
                        short_set = sense.over_cur[i];
                    end
                    if (short_set)
                    begin
                        c.phase = ipc_pkg::IPC_IDLE;
                    end
                    else if (!cmd)
                    begin
                        c.phase = ipc_pkg::IPC_IDLE;
                        open_set = !(s.ch[i].reached || hit);
                    end
                end
                default:
                begin
                    c.phase = ipc_pkg::IPC_IDLE;
                end
            endcase

            // Set wins over clear; short clear refused while commanded
            if (short_set)
            begin
                c.short_flag = 1'b1;
            end
            else if (short_clear_in[i] && !cmd)
            begin
                c.short_flag = 1'b0;
            end
            if (open_set)
            begin
                c.open_flag = 1'b1;
            end
            else if (open_clear_in[i])
            begin
                c.open_flag = 1'b0;
            end

            // Open flag plays no part in enabling the drive
            c.drive = (c.phase != ipc_pkg::IPC_IDLE);
            c.target_peak = (c.phase == ipc_pkg::IPC_PEAK);
            // Chop when the present target level is reached
            c.chop = c.drive &&
                (c.target_peak ? sense.at_peak[i] : sense.at_hold[i]);
            next_s.ch[i] = c;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_comb
    begin
        for (int i = 0; i < ipc_pkg::NCH; i++)
        begin
            drive_on_out[i] = s.ch[i].drive;
            target_peak_out[i] = s.ch[i].target_peak;
            chop_out[i] = s.ch[i].chop;
            short_flag_out[i] = s.ch[i].short_flag;
            open_flag_out[i] = s.ch[i].open_flag;
        end
    end

    assign peak_time_out = s.peak_time;
    assign peak_update_out = s.upd_pulse;

endmodule : ipc_injector_peak_hold_ctrl

// [verilog/ipc_pkg.sv]
package ipc_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int NCH = 4;
    localparam int PEAK_W = 16;

    // Microsecond time base
    localparam int US_CYCLES = CLK_HZ / 1_000_000;
    localparam int US_W = 5;
    localparam logic [US_W-1:0] US_LAST = US_W'(US_CYCLES - 1);

    // Peak time refresh interval
    localparam int UPDATE_US = 200;
    localparam int UPD_W = 8;
    localparam logic [UPD_W-1:0] UPD_LAST = UPD_W'(UPDATE_US - 1);

    // Length of the rise rate check at event start
    localparam int RISE_WINDOW_US = 20;
    localparam int WIN_W = 5;
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(RISE_WINDOW_US);

    localparam logic [PEAK_W-1:0] PEAK_RESET = 16'h0000;

    // Gray order along idle -> peak -> hold
    typedef enum logic [1:0]
    {
        IPC_IDLE = 2'b00,
        IPC_PEAK = 2'b01,
        IPC_HOLD = 2'b11
    } ipc_phase_t;

    // Comparator and sense lines from the analogue stage, one bit per channel
    typedef struct packed
    {
        logic [NCH-1:0] at_peak;
        logic [NCH-1:0] at_hold;
        logic [NCH-1:0] rise_fast;
        logic [NCH-1:0] over_cur;
    } ipc_sense_t;

    typedef struct packed
    {
        ipc_phase_t phase;
        logic [PEAK_W-1:0] peak_cnt;
        logic [WIN_W-1:0] win_cnt;
        logic cmd_prev;
        logic reached;
        logic short_flag;
        logic open_flag;
        logic drive;
        logic target_peak;
        logic chop;
    } ipc_chan_t;

    typedef struct packed
    {
        ipc_chan_t [NCH-1:0] ch;
        logic [US_W-1:0] us_div;
        logic [UPD_W-1:0] upd_cnt;
        logic [PEAK_W-1:0] peak_time;
        logic upd_pulse;
    } ipc_state_t;

endpackage : ipc_pkg

// [verilog/ipc_sync.sv]
`timescale 1ns/10ps
module ipc_sync
#(
    parameter int W = 16
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Asynchronous lines and their synchronised copies
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed
    {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } ipc_sync_state_t;

    ipc_sync_state_t s;
    ipc_sync_state_t next_s;

    // First stage feeds only the second stage
    always_comb
    begin
        next_s.first = async_in;
        next_s.second = s.first;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sync_out = s.second;

endmodule : ipc_sync

// [bench/ipc_checker.sv]
`timescale 1ns/10ps
module ipc_checker
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Host side and analogue sense lines
    input wire logic [3:0] inject_cmd_in,
    input wire logic [15:0] peak_time_in,
    input wire logic [3:0] short_clear_in,
    input wire logic [3:0] open_clear_in,
    input wire ipc_pkg::ipc_sense_t sense_in,
    // Driver and status
    input wire logic [3:0] drive_on_out,
    input wire logic [3:0] target_peak_out,
    input wire logic [3:0] chop_out,
    input wire logic [3:0] short_flag_out,
    input wire logic [3:0] open_flag_out,
    input wire logic [15:0] peak_time_out,
    input wire logic peak_update_out
);
    logic [15:0] gap;
    logic seen;
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gap <= 16'h0000;
            seen <= 1'b0;
        end
        else
        begin
            gap <= peak_update_out ? 16'h0001 : gap + 16'h0001;
            seen <= seen | peak_update_out;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence go;
        $rose(inject_cmd_in[0]) && !drive_on_out[0] && !short_flag_out[0];
    endsequence
    start_drive_a: assert property (go |=> drive_on_out[0])
        else $error("drive not on");
    peak_target_a: assert property (go |=> target_peak_out[0] ==
        ($past(peak_time_out) != 16'h0000)) else $error("bad target");
    cmd_end_a: assert property (!inject_cmd_in[0] |=> !drive_on_out[0])
        else $error("drive after end");
    short_off_a: assert property ((short_flag_out & drive_on_out) == 4'h0)
        else $error("shorted channel on");
    clear_held_a: assert property
        (short_flag_out[0] && inject_cmd_in[0] |=> short_flag_out[0])
        else $error("clear under command");
    short_keep_a: assert property
        (short_flag_out[0] && !short_clear_in[0] |=> short_flag_out[0])
        else $error("short flag lost");
    open_keep_a: assert property
        (open_flag_out[0] && !open_clear_in[0] |=> open_flag_out[0])
        else $error("open flag lost");
    open_end_a: assert property ($rose(open_flag_out[0]) |-> $fell(drive_on_out[0]))
        else $error("open not at end");
    upd_take_a: assert property
        (peak_update_out |-> peak_time_out == $past(peak_time_in))
        else $error("peak time not taken");
    upd_gap_a: assert property (peak_update_out && seen |-> gap == 16'h1388)
        else $error("update spacing");
    chop_level_a: assert property (chop_out[0] == (drive_on_out[0] &&
        (target_peak_out[0] ? $past(sense_in.at_peak[0], 3) : $past(sense_in.at_hold[0], 3))))
        else $error("chop level");
    cover property (go);
    cover property (chop_out[0]);
    cover property ($rose(short_flag_out[0]));
    cover property ($rose(open_flag_out[0]));
endmodule : ipc_checker

bind ipc_injector_peak_hold_ctrl ipc_checker u_chk
(
    .clock_in(clock_in), .rst_in(rst_in), .inject_cmd_in(inject_cmd_in),
    .peak_time_in(peak_time_in), .short_clear_in(short_clear_in),
    .open_clear_in(open_clear_in), .sense_in(sense_in), .drive_on_out(drive_on_out),
    .target_peak_out(target_peak_out), .chop_out(chop_out),
    .short_flag_out(short_flag_out), .open_flag_out(open_flag_out),
    .peak_time_out(peak_time_out), .peak_update_out(peak_update_out)
);

// [bench/ipc_load.sv]
`timescale 1ns/10ps
module ipc_load
(
    // Clock and driver controls
    input wire logic clock_in,
    input wire logic [3:0] drive_in,
    input wire logic [3:0] target_in,
    // Load kind per channel: 0 good, 1 open, 2 fast rise, 3 late overcurrent
    input wire logic [7:0] mode_in,
    // Comparator lines
    output ipc_pkg::ipc_sense_t sense_out
);
    logic [3:0][7:0] on_cnt = '0;
    always_ff @(posedge clock_in)
    begin
        for (int i = 0; i < 4; i++)
        begin
            on_cnt[i] <= drive_in[i] ? on_cnt[i] + {7'h00, ~&on_cnt[i]} : 8'h00;
        end
    end
    // Current builds up only while driven, so released lines read low
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            sense_out.at_hold[i] = mode_in[2*i+:2] != 2'h1 && on_cnt[i] >= 8'h04;
            sense_out.at_peak[i] = sense_out.at_hold[i] && target_in[i] && on_cnt[i] >= 8'h08;
            sense_out.rise_fast[i] = drive_in[i] && mode_in[2*i+:2] == 2'h2;
            sense_out.over_cur[i] = drive_in[i] && mode_in[2*i+:2] == 2'h3;
        end
    end
endmodule : ipc_load

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
    typedef struct {int ch; int mode; int len; logic [2:0] exp;} ipc_row_t;
    logic clock_in;
    logic rst_in;
    logic [3:0] cmd, sclr, oclr, drv, tgt, chop, sflag, oflag;
    logic [15:0] pt_in, pt_out;
    logic upd;
    logic [7:0] mode;
    ipc_pkg::ipc_sense_t sense;
    int bad_count;
    int checks;
    int tp;
    // Channel, load kind, cycles; expect short, open, peak length in range
    ipc_row_t rows [5] = '{'{0, 0, 200, 3'b001}, '{0, 1, 200, 3'b011},
        '{1, 2, 200, 3'b100}, '{2, 3, 700, 3'b101}, '{3, 3, 200, 3'b001}};
    ipc_injector_peak_hold_ctrl dut (.clock_in(clock_in), .rst_in(rst_in),
        .inject_cmd_in(cmd), .peak_time_in(pt_in), .short_clear_in(sclr),
        .open_clear_in(oclr), .sense_in(sense), .drive_on_out(drv),
        .target_peak_out(tgt), .chop_out(chop), .short_flag_out(sflag),
        .open_flag_out(oflag), .peak_time_out(pt_out), .peak_update_out(upd));
    ipc_load load (.clock_in(clock_in), .drive_in(drv), .target_in(tgt),
        .mode_in(mode), .sense_out(sense));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic results;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic pulse(input int ch, input int len);
        @(posedge clock_in);
        cmd[ch] <= 1'b1;
        tp = 0;
        repeat (len)
        begin
            @(negedge clock_in);
            tp += int'(tgt[ch]);
        end
        @(posedge clock_in);
        cmd[ch] <= 1'b0;
        repeat (3) @(negedge clock_in);
    endtask : pulse
    task automatic run(input ipc_row_t r);
        @(posedge clock_in);
        mode[2*r.ch+:2] <= 2'(r.mode);
        pulse(r.ch, r.len);
        check("drive", drv[r.ch], 1'b0);
        check("short", sflag[r.ch], r.exp[2]);
        check("open", oflag[r.ch], r.exp[1]);
        check("peak", tp >= 50 && tp <= 75, r.exp[0]);
        @(posedge clock_in);
        {sclr, oclr} <= 8'hFF;
        @(posedge clock_in);
        {sclr, oclr} <= 8'h00;
        @(negedge clock_in);
        check("flags", {sflag, oflag}, 8'h00);
    endtask : run
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial
    begin
        #800000;
        bad_count++;
        results;
    end
    initial
    begin
        {cmd, sclr, oclr, mode} = 20'h00000;
        rst_in = 1'b1;
        pt_in = 16'h0003;
        repeat (10) @(posedge clock_in);
        check("rst", {drv, tgt, sflag, oflag}, 16'h0000);
        rst_in <= 1'b0;
        repeat (5100) @(posedge clock_in);
        check("ptime", pt_out, 16'h0003);
        foreach (rows[i])
            run(rows[i]);
        @(posedge clock_in);
        mode[1:0] <= 2'h2;
        @(posedge clock_in);
        cmd[0] <= 1'b1;
        repeat (10) @(posedge clock_in);
        sclr[0] <= 1'b1;
        repeat (3) @(negedge clock_in);
        check("held", {sflag[0], drv[0]}, 2'b10);
        @(posedge clock_in);
        cmd[0] <= 1'b0;
        repeat (3) @(negedge clock_in);
        check("freed", sflag[0], 1'b0);
        @(posedge clock_in);
        sclr[0] <= 1'b0;
        mode[1:0] <= 2'h1;
        pulse(0, 100);
        @(posedge clock_in);
        mode[1:0] <= 2'h0;
        pulse(0, 100);
        check("reuse", {oflag[0], tp >= 50 && tp <= 75}, 2'b11);
        @(posedge clock_in);
        pt_in <= 16'h0000;
        mode <= 8'h00;
        repeat (5000) @(posedge clock_in);
        pulse(1, 200);
        check("nopeak", 16'(tp), 16'h0000);
        @(posedge clock_in);
        mode[5:4] <= 2'h3;
        cmd[2] <= 1'b1;
        repeat (20) @(posedge clock_in);
        @(negedge clock_in);
        check("alone", drv, 4'h4);
        @(posedge clock_in);
        rst_in <= 1'b1;
        @(negedge clock_in);
        check("rst2", {drv, tgt, sflag, oflag}, 16'h0000);
        results;
    end
endmodule : tb
